// ===== core/tx_ctrl.v
// tape extended-operations control: register, pause, skip, interrupt, trap
`timescale 1ns/1ps
`default_nettype none
`include "tx_map.vh"

// Operation
// RULE_01 - enable bit requests interrupt when tape idle
// RULE_02 - native interrupt saves 0040, resumes 0041 field0
// RULE_03 - alternate mode uses locations 0000 and 0001
// RULE_04 - without no-pause processor stalls until done
// RULE_05 - with no-pause processor resumes after start
// RULE_06 - no-pause suppresses transfer check to accumulator
// RULE_07 - done skip on complete or running by I
// RULE_08 - done skip equals external level sixteen skip
// RULE_09 - deselected transport stops by default
// RULE_10 - hold bit keeps deselected transport moving
// RULE_11 - hold separate from per-instruction motion bit
// RULE_12 - mark flop needs switch and bit four load
// RULE_13 - maintenance blocks reader-writer timing and data
// RULE_14 - maintenance feeds control from transfer-instruction signals
// RULE_15 - both traps enabled suppress tape instructions
// RULE_16 - trapped tape instruction goes to 0140 field0
// RULE_17 - load and read register, source unchanged
// RULE_18 - done flag clears at start, sets at end
// RULE_19 - interrupt request is a steady level
module tx_ctrl #(
    parameter UNIT_W = 3
) (
    // clock and reset
    input  wire              i_clock,
    input  wire              i_rst,
    // processor instruction strobe and operands
    input  wire              i_instr_valid,
    input  wire [11:0]       i_instr,
    input  wire [11:0]       i_accumulator,
    input  wire              i_alt_mode,
    input  wire              i_transfer_check_valid,
    input  wire [11:0]       i_transfer_check,
    // console mark switch and reader-writer signals (asynchronous)
    input  wire              i_mark_switch,
    input  wire              i_rw_timing,
    input  wire              i_rw_data,
    input  wire              i_tape_end,
    // maintenance substitutes from transfer instructions
    input  wire              i_maint_timing,
    input  wire              i_maint_data,
    input  wire              i_maint_end,
    // transport selection and motion
    input  wire [UNIT_W-1:0] i_unit_sel,
    input  wire              i_unit_sel_valid,
    input  wire              i_motion_bit,
    input  wire              i_motion_dir,
    // processor-facing results
    output reg  [11:0]       o_ac_data,
    output reg               o_ac_load,
    output reg               o_skip,
    output reg               o_stall,
    output reg               o_irq,
    output reg               o_vector_valid,
    output reg  [11:0]       o_vector_save,
    output reg  [11:0]       o_vector_go,
    output reg  [2:0]        o_vector_field,
    output reg               o_tape_start,
    output reg               o_tape_done,
    // tape-facing results
    output reg               o_ctl_timing,
    output reg               o_ctl_data,
    output reg  [11:0]       o_tape_extended_control,
    output reg               o_format_mark,
    output reg  [UNIT_W-1:0] o_unit_active,
    output reg  [(1<<UNIT_W)-1:0] o_unit_run,
    output reg  [(1<<UNIT_W)-1:0] o_unit_dir
);
    localparam NU = 1 << UNIT_W;

    // state machine
    localparam ST_IDLE = 2'b00;
    localparam ST_BUSY = 2'b01;
    localparam ST_ACK  = 2'b10;

    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [11:0] xc_r;
    reg  [1:0]  esf_r;
    wire [2:0]  rw_sync;
    wire        sw_sync;
    wire        ctl_end;
    wire        is_tape;
    wire        is_std;
    wire        is_sxl16;
    wire        trap_on;
    wire        bit_ien;
    wire        bit_np;
    wire        bit_hold;
    wire        bit_maint;
    wire        idle_now;
    integer     u;

    // bit 0 of the word is the msb
    assign bit_ien   = xc_r[11-`TX_BIT_IEN];
    assign bit_np    = xc_r[11-`TX_BIT_NOPAUSE];
    assign bit_hold  = xc_r[11-`TX_BIT_HOLD];
    assign bit_maint = xc_r[11-`TX_BIT_MAINT];
    assign trap_on   = esf_r[0] & esf_r[1];
    assign is_tape   = i_instr_valid
                     & ((i_instr & `TX_OP_TAPE_MASK) == `TX_OP_TAPE_BASE);
    assign is_std    = (i_instr & `TX_OP_STD_MASK) == `TX_OP_STD; // RULE_07
    assign is_sxl16  = (i_instr & `TX_OP_STD_MASK)
                     == (`TX_OP_SXL_BASE | {8'h00, `TX_STD_LEVEL}); // RULE_08
    assign idle_now  = (state_r == ST_IDLE);

    // pins are synchronised before use
    tx_sync3 #(.WIDTH(3)) u_rw_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async ({i_rw_timing, i_rw_data, i_tape_end}),
        .o_sync  (rw_sync)
    );
    tx_sync3 #(.WIDTH(1)) u_sw_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_mark_switch),
        .o_sync  (sw_sync)
    );

    // maintenance substitutes transfer-instruction signals for the heads
    assign ctl_end = bit_maint ? i_maint_end : rw_sync[0]; // RULE_13

    // next-state logic for the tape operation sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (is_tape && !trap_on) begin // RULE_15
                    state_nxt = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (ctl_end) begin
                    state_nxt = ST_ACK;
                end
            end
            ST_ACK: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // register file, sequencer and processor answers
    always @(posedge i_clock) begin
        if (i_rst) begin
            state_r                 <= ST_IDLE;
            xc_r                    <= `TX_XC_RESET;
            esf_r                   <= 2'b00;
            o_ac_data               <= 12'h000;
            o_ac_load               <= 1'b0;
            o_skip                  <= 1'b0;
            o_stall                 <= 1'b0;
            o_irq                   <= 1'b0;
            o_vector_valid          <= 1'b0;
            o_vector_save           <= 12'h000;
            o_vector_go             <= 12'h000;
            o_vector_field          <= 3'h0;
            o_tape_start            <= 1'b0;
            o_tape_done             <= 1'b1;
            o_ctl_timing            <= 1'b0;
            o_ctl_data              <= 1'b0;
            o_tape_extended_control <= `TX_XC_RESET;
            o_format_mark           <= 1'b0;
        end else begin
            state_r        <= state_nxt;
            o_ac_load      <= 1'b0;
            o_skip         <= 1'b0;
            o_vector_valid <= 1'b0;
            o_tape_start   <= 1'b0;
            // load register from accumulator, accumulator untouched
            if (i_instr_valid && i_instr == `TX_OP_AXO) begin
                xc_r                    <= i_accumulator; // RULE_17
                o_tape_extended_control <= i_accumulator;
                // mark flop only with switch held and bit four set
                o_format_mark <= sw_sync
                               & i_accumulator[11-`TX_BIT_MARK]; // RULE_12
            end
            // register copied to accumulator
            if (i_instr_valid && i_instr == `TX_OP_XOA) begin
                o_ac_data <= xc_r; // RULE_17
                o_ac_load <= 1'b1;
            end
            // special-function enable bits captured from the accumulator
            if (i_instr_valid && i_instr[11:4] == 8'h00 && i_instr[3:0] == 4'h4) begin
                esf_r <= {i_accumulator[11-`TX_ESF_TAPE],
                          i_accumulator[11-`TX_ESF_INSTR]}; // RULE_15
            end
            // done skip: I=0 skips when complete, I=1 while running
            if (i_instr_valid && (is_std || is_sxl16)) begin
                o_skip <= i_instr[4] ? !o_tape_done : o_tape_done; // RULE_07 RULE_08
            end
            // trapped tape instruction vectors to field 0 location 0140
            if (is_tape && trap_on) begin
                o_vector_valid <= 1'b1; // RULE_16
                o_vector_save  <= `TX_VEC_TRAP;
                o_vector_go    <= `TX_VEC_TRAP + 12'h001;
                o_vector_field <= `TX_FIELD_ZERO;
            end else if (o_irq && !o_vector_valid && !i_instr_valid) begin
                o_vector_valid <= 1'b1;
                o_vector_field <= `TX_FIELD_ZERO; // RULE_02
                o_vector_save  <= i_alt_mode ? `TX_VEC_ALT_SAVE : `TX_VEC_NAT_SAVE; // RULE_03
                o_vector_go    <= i_alt_mode ? `TX_VEC_ALT_GO : `TX_VEC_NAT_GO; // RULE_02 RULE_03
            end
            // start: done clears, stall unless no-pause
            if (idle_now && state_nxt == ST_BUSY) begin
                o_tape_start <= 1'b1;
                o_tape_done  <= 1'b0; // RULE_18
                o_stall      <= !bit_np; // RULE_04 RULE_05
            end
            // completion: done sets, stall releases; check to accumulator any cycle while not idle and no-pause clear
            if (state_r == ST_BUSY && ctl_end) begin
                o_tape_done <= 1'b1; // RULE_18
                o_stall     <= 1'b0; // RULE_04
            end
            if (i_transfer_check_valid && !bit_np && state_r != ST_IDLE) begin
                o_ac_data <= i_transfer_check; // RULE_06
                o_ac_load <= 1'b1;
            end
            // steady interrupt level while enabled and idle
            o_irq <= bit_ien & (state_nxt == ST_IDLE); // RULE_01 RULE_19
            // heads feed the control only outside maintenance
            o_ctl_timing <= bit_maint ? i_maint_timing : rw_sync[2]; // RULE_13 RULE_14
            o_ctl_data   <= bit_maint ? i_maint_data : rw_sync[1]; // RULE_14
        end
    end

    // transport selection and motion per unit
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_unit_active <= {UNIT_W{1'b0}};
            o_unit_run    <= {NU{1'b0}};
            o_unit_dir    <= {NU{1'b0}};
        end else begin
            if (i_unit_sel_valid && i_unit_sel != o_unit_active) begin
                o_unit_active <= i_unit_sel;
                // deselected unit stops unless hold keeps it running
                if (!bit_hold) begin
                    o_unit_run[o_unit_active] <= 1'b0; // RULE_09 RULE_10
                end
                o_unit_run[i_unit_sel] <= 1'b1;
            end else if (idle_now && is_tape && !trap_on) begin
                o_unit_run[o_unit_active] <= 1'b1;
                o_unit_dir[o_unit_active] <= i_motion_dir;
            end else if (state_r == ST_BUSY && ctl_end) begin
                // motion bit decides only at instruction completion
                o_unit_run[o_unit_active] <= i_motion_bit; // RULE_11
            end
            for (u = 0; u < NU; u = u + 1) begin
                if (u[UNIT_W-1:0] == o_unit_active && state_r == ST_BUSY) begin
                    o_unit_dir[u] <= i_motion_dir;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== core/tx_sync3.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module tx_sync3 #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             i_clock,
    input  wire             i_rst,
    // asynchronous input and filtered result
    input  wire [WIDTH-1:0] i_async,
    output reg  [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;

    // result changes only once stages two and three agree per bit
    always @(posedge i_clock) begin
        if (i_rst) begin
            s1_r   <= {WIDTH{1'b0}};
            s2_r   <= {WIDTH{1'b0}};
            s3_r   <= {WIDTH{1'b0}};
            o_sync <= {WIDTH{1'b0}};
        end else begin
            s1_r   <= i_async;
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            o_sync <= (s2_r & s3_r) | (o_sync & (s2_r | s3_r));
        end
    end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the tape extended-operations control block
`timescale 1ns/1ps
`default_nettype none
`include "tx_map.vh"
module tb;
    logic        i_clock = 1'b0;
    logic        i_rst   = 1'b1;
    logic        ivalid  = 1'b0;
    logic [11:0] instr   = 12'h000;
    logic [11:0] acc     = 12'h000;
    logic        alt     = 1'b0;
    logic        tcv     = 1'b0;
    logic        mswitch = 1'b0;
    logic        rw      = 1'b0;
    logic        mtime   = 1'b0;
    logic        mend    = 1'b0;
    logic        mbit    = 1'b0;
    logic        mdir    = 1'b0;
    logic        usv     = 1'b0;
    logic [2:0]  usel    = 3'h0;
    logic        tape_end;
    logic [11:0] ac_data, xc, vsave, vgo;
    logic [7:0]  urun, udir;
    logic [2:0]  uact, vfield;
    logic        ac_load, skip, stall, irq, vvalid, start, done, ctl_t, ctl_d, fmark;
    integer      err_count = 0;
    integer      samples_checked = 0;
    integer      k;

    // 40 MHz clock
    always #12.5 i_clock = ~i_clock;

    tx_ctrl i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_instr_valid(ivalid), .i_instr(instr),
        .i_accumulator(acc), .i_alt_mode(alt), .i_transfer_check_valid(tcv),
        .i_transfer_check(12'hfff), .i_mark_switch(mswitch), .i_rw_timing(rw), .i_rw_data(rw),
        .i_tape_end(tape_end), .i_maint_timing(mtime), .i_maint_data(mtime), .i_maint_end(mend),
        .i_unit_sel(usel), .i_unit_sel_valid(usv), .i_motion_bit(mbit), .i_motion_dir(mdir),
        .o_ac_data(ac_data), .o_ac_load(ac_load), .o_skip(skip), .o_stall(stall), .o_irq(irq),
        .o_vector_valid(vvalid), .o_vector_save(vsave), .o_vector_go(vgo),
        .o_vector_field(vfield),
        .o_tape_start(start), .o_tape_done(done), .o_ctl_timing(ctl_t), .o_ctl_data(ctl_d),
        .o_tape_extended_control(xc), .o_format_mark(fmark), .o_unit_active(uact),
        .o_unit_run(urun), .o_unit_dir(udir));

    tx_tape_model i_tape (.i_clock(i_clock), .i_start(start), .o_tape_end(tape_end));

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one instruction, held for one taking edge
    task automatic run(input logic [11:0] op, input logic [11:0] ac);
        @(negedge i_clock);
        ivalid = 1'b1;
        instr = op;
        acc = ac;
        @(negedge i_clock);
        ivalid = 1'b0;
    endtask

    task automatic wait_hi(ref logic s, input int lim);
        for (int n = 0; n < lim && s !== 1'b1; n++) @(negedge i_clock);
    endtask

    // transport selection, held for one taking edge
    task automatic pick(input logic [2:0] u);
        @(negedge i_clock);
        usel = u;
        usv = 1'b1;
        @(negedge i_clock);
        usv = 1'b0;
    endtask

    // both forms of the done skip against the expected done state
    task automatic skips(input logic d);
        for (int i = 0; i < 2; i++) begin
            run(`TX_OP_STD | (i << 4), 12'h000);
            chk({11'h0, skip}, {11'h0, (i == 1) ? ~d : d}, "skip");
        end
    endtask

    task automatic give_verdict;
        if (err_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // watchdog
    initial begin
        #(25 * 4000);
        err_count++;
        give_verdict;
    end

    initial begin
        repeat (16) @(negedge i_clock);
        i_rst = 1'b0;
        chk(xc, `TX_XC_RESET, "xc reset");
        chk({11'h0, done}, 12'h001, "done reset");
        run(`TX_OP_AXO, 12'ha5c);
        chk(xc, 12'ha5c, "xc load");
        run(`TX_OP_XOA, 12'h000);
        chk(ac_data, 12'ha5c, "xc read");
        chk({11'h0, ac_load}, 12'h001, "xc read load");
        run(`TX_OP_AXO, 12'h040);
        repeat (2) @(negedge i_clock);
        chk({11'h0, irq}, 12'h001, "irq idle");
        run(`TX_OP_TAPE_BASE, 12'h000);
        chk({10'h0, done, stall}, 12'h001, "start pause");
        skips(1'b0);
        tcv = 1'b1;
        @(negedge i_clock);
        tcv = 1'b0;
        chk(ac_data, 12'hfff, "check loaded");
        chk({11'h0, irq}, 12'h000, "irq busy");
        wait_hi(done, 200);
        @(negedge i_clock);
        chk({10'h0, irq, stall}, 12'h002, "end pause");
        skips(1'b1);
        for (k = 0; k < 2; k++) begin
            alt = k[0];
            repeat (2) @(negedge i_clock);
            wait_hi(vvalid, 8);
            chk(vsave, k ? `TX_VEC_ALT_SAVE : `TX_VEC_NAT_SAVE, "vector save");
            chk(vgo, k ? `TX_VEC_ALT_GO : `TX_VEC_NAT_GO, "vector go");
            chk({9'h0, vfield}, 12'h000, "vector field");
        end
        alt = 1'b0;
        run(`TX_OP_AXO, 12'h008);
        run(`TX_OP_TAPE_BASE, 12'h000);
        chk({11'h0, stall}, 12'h000, "no pause");
        tcv = 1'b1;
        @(negedge i_clock);
        tcv = 1'b0;
        chk({11'h0, ac_load}, 12'h000, "check held");
        wait_hi(done, 200);
        run(`TX_OP_AXO, 12'h020);
        rw = 1'b1;
        repeat (6) @(negedge i_clock);
        chk({10'h0, ctl_t, ctl_d}, 12'h000, "rw blocked");
        mtime = 1'b1;
        repeat (2) @(negedge i_clock);
        chk({10'h0, ctl_t, ctl_d}, 12'h003, "maint timing");
        run(`TX_OP_TAPE_BASE, 12'h000);
        repeat (40) @(negedge i_clock);
        chk({11'h0, done}, 12'h000, "end blocked");
        mend = 1'b1;
        @(negedge i_clock);
        mend = 1'b0;
        repeat (2) @(negedge i_clock);
        chk({11'h0, done}, 12'h001, "maint end");
        rw = 1'b0;
        mtime = 1'b0;
        run(`TX_OP_AXO, 12'h080);
        chk({11'h0, fmark}, 12'h000, "mark no switch");
        mswitch = 1'b1;
        repeat (6) @(negedge i_clock);
        run(`TX_OP_AXO, 12'h080);
        chk({11'h0, fmark}, 12'h001, "mark set");
        mswitch = 1'b0;
        run(`TX_OP_AXO, 12'h000);
        // transport motion: completion bit, deselect stop, hold keeps moving
        mbit = 1'b1;
        mdir = 1'b1;
        run(`TX_OP_TAPE_BASE, 12'h000);
        wait_hi(done, 200);
        repeat (10) @(negedge i_clock);
        chk({4'h0, urun[3:0], udir[3:0]}, 12'h011, "motion after op");
        pick(3'h1);
        chk({9'h0, uact}, 12'h001, "unit selected");
        chk({4'h0, urun}, 12'h002, "deselect stops");
        run(`TX_OP_TAPE_BASE, 12'h000);
        wait_hi(done, 200);
        repeat (10) @(negedge i_clock);
        mdir = 1'b0;
        mbit = 1'b0;
        run(`TX_OP_AXO, 12'h004);
        pick(3'h0);
        chk({4'h0, urun[3:0], udir[3:0]}, 12'h033, "hold keeps moving");
        run(`TX_OP_TAPE_BASE, 12'h000);
        chk({4'h0, urun[3:0], udir[3:0]}, 12'h032, "motion mid op");
        wait_hi(done, 200);
        repeat (10) @(negedge i_clock);
        chk({4'h0, urun[3:0], udir[3:0]}, 12'h022, "motion at end");
        run(12'h004, 12'h300);
        run(`TX_OP_TAPE_BASE, 12'h000);
        chk(vsave, `TX_VEC_TRAP, "trap save");
        chk(vgo, `TX_VEC_TRAP + 12'h001, "trap go");
        chk({9'h0, vfield}, 12'h000, "trap field");
        chk({10'h0, vvalid, start}, 12'h002, "trap only");
        give_verdict;
    end
endmodule
`default_nettype wire

// ===== dv/tx_ctrl_sva.sv
// assertion checker bound to the tape extended-operations control
`timescale 1ns/1ps
`default_nettype none
`include "tx_map.vh"
module tx_ctrl_sva (
    // clock, reset and processor inputs
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_instr_valid,
    input wire logic [11:0] i_instr,
    input wire logic [11:0] i_accumulator,
    input wire logic        i_transfer_check_valid,
    input wire logic        i_maint_timing,
    // design outputs
    input wire logic [11:0] o_ac_data,
    input wire logic        o_ac_load,
    input wire logic        o_skip,
    input wire logic        o_stall,
    input wire logic        o_irq,
    input wire logic        o_vector_valid,
    input wire logic [11:0] o_vector_save,
    input wire logic [11:0] o_vector_go,
    input wire logic        o_tape_start,
    input wire logic        o_tape_done,
    input wire logic        o_ctl_timing,
    input wire logic [11:0] o_tape_extended_control,
    input wire logic        o_format_mark
);
    logic inv_q;
    logic mark_q;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // skip polarity and marked load, one cycle late
    always @(posedge i_clock) begin
        inv_q  <= i_instr[4];
        mark_q <= i_instr_valid && i_instr == `TX_OP_AXO && i_accumulator[11-`TX_BIT_MARK];
    end

    sequence load_s; i_instr_valid && i_instr == `TX_OP_AXO; endsequence
    sequence read_s; i_instr_valid && i_instr == `TX_OP_XOA; endsequence
    sequence skip_s; i_instr_valid && (i_instr & `TX_OP_STD_MASK) == `TX_OP_STD; endsequence
    sequence maint_s; o_tape_extended_control[11-`TX_BIT_MAINT] [*2]; endsequence

    reg_load_a: assert property (
        load_s |=> o_tape_extended_control == $past(i_accumulator))
        else $error("register load mismatch");
    reg_read_a: assert property (
        read_s |=> o_ac_load && o_ac_data == $past(o_tape_extended_control))
        else $error("register read mismatch");
    done_skip_a: assert property (
        skip_s |=> o_skip == ($past(o_tape_done) ^ inv_q))
        else $error("done skip wrong");
    start_clear_a: assert property (o_tape_start |-> !o_tape_done && !o_irq)
        else $error("done not cleared at start");
    pause_mode_a: assert property (
        o_tape_start |-> o_stall != o_tape_extended_control[11-`TX_BIT_NOPAUSE])
        else $error("stall level wrong");
    irq_idle_a: assert property (o_irq |-> o_tape_done)
        else $error("interrupt while busy");
    // a load that clears the enable drops the level two cycles later
    irq_hold_a: assert property (
        o_irq && !i_instr_valid && o_tape_extended_control[11-`TX_BIT_IEN] |=> o_irq)
        else $error("interrupt level dropped");
    vec_pair_a: assert property (
        o_vector_valid |-> o_vector_go == o_vector_save + 12'h001)
        else $error("vector pair wrong");
    check_held_a: assert property (
        i_transfer_check_valid && !i_instr_valid && o_tape_extended_control[11-`TX_BIT_NOPAUSE]
        |=> !o_ac_load)
        else $error("transfer check loaded");
    maint_path_a: assert property (
        maint_s |-> o_ctl_timing == $past(i_maint_timing))
        else $error("maintenance timing path wrong");
    mark_set_a: assert property ($rose(o_format_mark) |-> mark_q)
        else $error("mark set without load");
endmodule

bind tx_ctrl tx_ctrl_sva i_chk (.i_clock(i_clock), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_accumulator(i_accumulator), .i_transfer_check_valid(i_transfer_check_valid),
    .i_maint_timing(i_maint_timing), .o_ac_data(o_ac_data), .o_ac_load(o_ac_load), .o_skip(o_skip),
    .o_stall(o_stall), .o_irq(o_irq), .o_vector_valid(o_vector_valid), .o_vector_save(o_vector_save),
    .o_vector_go(o_vector_go), .o_tape_start(o_tape_start), .o_tape_done(o_tape_done),
    .o_ctl_timing(o_ctl_timing), .o_tape_extended_control(o_tape_extended_control),
    .o_format_mark(o_format_mark));
`default_nettype wire

// ===== dv/tx_tape_model.sv
// stand-in for the tape transports: answers each started operation with an end level
`timescale 1ns/1ps
`default_nettype none
module tx_tape_model #(
    parameter DELAY = 20
) (
    // clock
    input  wire logic i_clock,
    // start pulse from the control and end level back to it
    input  wire logic i_start,
    output var  logic o_tape_end
);
    integer cnt = 0;

    // count down after a start, then hold the end level long enough to pass the synchroniser
    always @(posedge i_clock) begin
        if (i_start) begin
            cnt <= DELAY + 8;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end

    // end level stays low outside the answer window
    always @* begin
        o_tape_end = (cnt > 0) && (cnt <= 8);
    end
endmodule
`default_nettype wire

// ===== pkg/tx_map.vh
// constant map for the tape extended-operations control block
`ifndef TX_MAP_VH
`define TX_MAP_VH

// extended-control register bit positions (bit 0 is the msb, 12-bit word)
`define TX_BIT_MARK       4
`define TX_BIT_MAINT      6
`define TX_BIT_NOPAUSE    8
`define TX_BIT_HOLD       9
`define TX_BIT_IEN        5
`define TX_XC_RESET       12'h000

// instruction codes (octal values written in hex)
`define TX_OP_AXO         12'h001
`define TX_OP_XOA         12'h011
`define TX_OP_STD         12'h10e
`define TX_OP_STD_MASK    12'hfef
`define TX_OP_SXL_BASE    12'h100
`define TX_STD_LEVEL      4'he
`define TX_OP_TAPE_BASE   12'h1c0
`define TX_OP_TAPE_MASK   12'hfc0

// vector addresses (octal 0040, 0041, 0000, 0001, 0140)
`define TX_VEC_NAT_SAVE   12'h020
`define TX_VEC_NAT_GO     12'h021
`define TX_VEC_ALT_SAVE   12'h000
`define TX_VEC_ALT_GO     12'h001
`define TX_VEC_TRAP       12'h060
`define TX_FIELD_ZERO     3'h0

// special-function bits (accumulator bits 2 and 3)
`define TX_ESF_TAPE       2
`define TX_ESF_INSTR      3

`endif
